/* emoe_pkg.sv */
package emoe_pkg;

  // direct-space locations of the hardware registers
  localparam logic [7:0] ADDR_ACC    = 8'hE0;
  localparam logic [7:0] ADDR_AUX    = 8'hF0;
  localparam logic [7:0] ADDR_PSW    = 8'hD0;
  localparam logic [7:0] ADDR_PTRLO  = 8'h82;
  localparam logic [7:0] ADDR_PTRHI  = 8'h83;
  localparam logic [7:0] ADDR_GPPORT = 8'h90;
  localparam logic [7:0] ADDR_HIPORT = 8'hA0;

  // status word fields
  localparam int PSW_CY  = 7;
  localparam int PSW_RSH = 4;
  localparam int PSW_RSL = 3;
  localparam int PSW_EXCESS = 2;

  // values after reset
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [7:0]  RST_PORT  = 8'hFF;
  localparam logic [15:0] RST_PC    = 16'h0000;

  // opcodes
  localparam logic [7:0] OP_IDLE    = 8'h00;
  localparam logic [6:0] OP_XRD_IDX = 7'h71;
  localparam logic [7:0] OP_XRD_DP  = 8'hE0;
  localparam logic [6:0] OP_XWR_IDX = 7'h79;
  localparam logic [7:0] OP_XWR_DP  = 8'hF0;
  localparam logic [7:0] OP_PROD    = 8'hA4;
  localparam logic [4:0] OP_OR_REG  = 5'h09;
  localparam logic [6:0] OP_OR_IND  = 7'h23;
  localparam logic [7:0] OP_OR_DIR  = 8'h45;
  localparam logic [7:0] OP_OR_IMM  = 8'h44;
  localparam logic [7:0] OP_OR_DIRA = 8'h42;
  localparam logic [7:0] OP_OR_DIRI = 8'h43;

  // multiply takes four machine cycles, the first one is the decode
  localparam logic [1:0] PROD_LAST = 2'h3;

  // instruction classes of this slice
  typedef enum logic [3:0] {
    CLS_IDLE, CLS_XRD_IDX, CLS_XRD_DP, CLS_XWR_IDX, CLS_XWR_DP, CLS_PROD,
    CLS_OR_REG, CLS_OR_IND, CLS_OR_DIR, CLS_OR_IMM, CLS_OR_DIRA, CLS_OR_DIRI,
    CLS_OTHER
  } emoe_cls_e;

  // sequencer states
  typedef enum logic [1:0] {ST_EXEC, ST_XDATA, ST_PROD} emoe_state_e;

  // code bytes at the program counter
  typedef struct packed {
    logic [7:0] op;    // opcode
    logic [7:0] arg1;  // second byte
    logic [7:0] arg2;  // third byte
  } emoe_code_s;

  // multiplexed external bus
  typedef struct packed {
    logic       ale;      // address latch strobe
    logic       rdStb_b;  // read strobe
    logic       wrStb_b;  // write strobe
    logic [7:0] lowOut;   // low port drive value
    logic       lowOe;    // low port driven
    logic [7:0] highOut;  // high port value
  } emoe_xbus_s;

  // opcode to class
  function automatic emoe_cls_e emoe_decode(input logic [7:0] op);
    emoe_cls_e c;
    c = CLS_OTHER;
    if (op == OP_IDLE) c = CLS_IDLE;
    else if (op[7:1] == OP_XRD_IDX) c = CLS_XRD_IDX;
    else if (op == OP_XRD_DP) c = CLS_XRD_DP;
    else if (op[7:1] == OP_XWR_IDX) c = CLS_XWR_IDX;
    else if (op == OP_XWR_DP) c = CLS_XWR_DP;
    else if (op == OP_PROD) c = CLS_PROD;
    else if (op[7:3] == OP_OR_REG) c = CLS_OR_REG;
    else if (op[7:1] == OP_OR_IND) c = CLS_OR_IND;
    else if (op == OP_OR_DIR) c = CLS_OR_DIR;
    else if (op == OP_OR_IMM) c = CLS_OR_IMM;
    else if (op == OP_OR_DIRA) c = CLS_OR_DIRA;
    else if (op == OP_OR_DIRI) c = CLS_OR_DIRI;
    return c;
  endfunction : emoe_decode

  // instruction length in bytes
  function automatic logic [15:0] emoe_len(input emoe_cls_e c);
    logic [15:0] n;
    n = 16'h0001;
    if (c == CLS_OR_DIR || c == CLS_OR_IMM || c == CLS_OR_DIRA) n = 16'h0002;
    if (c == CLS_OR_DIRI) n = 16'h0003;
    return n;
  endfunction : emoe_len

endpackage : emoe_pkg

/* emoe_mul8.sv */
`timescale 1ns/100ps
module emoe_mul8
  import emoe_pkg::*;
(
  input  wire logic        sys_clk,   // machine-cycle clock
  input  wire logic        rst_b,     // async reset
  input  wire logic        start,     // load operands, first step
  input  wire logic [7:0]  facA,      // multiplicand
  input  wire logic [7:0]  facB,      // multiplier
  output logic             done,      // final step this cycle
  output logic [15:0]      product    // valid while done
);

  logic [15:0] acc_reg;  // partial sum
  logic [7:0]  a_reg;    // held multiplicand
  logic [7:0]  b_reg;    // held multiplier
  logic [1:0]  cnt_reg;  // step index
  logic        busy_reg; // steps pending

  // two multiplier bits per step, shifted into place
  function automatic logic [15:0] step(input logic [7:0] a, input logic [1:0] bits,
                                       input logic [1:0] k);
    logic [15:0] p;
    p = {8'h00, a} * {14'h0000, bits};
    return p << {k, 1'b0};
  endfunction : step

  assign done    = busy_reg && (cnt_reg == PROD_LAST);
  assign product = acc_reg + step(a_reg, b_reg[7:6], PROD_LAST);

  // step sequencing
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg  <= 16'h0000;
      a_reg    <= 8'h00;
      b_reg    <= 8'h00;
      cnt_reg  <= 2'h0;
      busy_reg <= 1'b0;
    end else if (start) begin
      acc_reg  <= step(facA, facB[1:0], 2'h0);
      a_reg    <= facA;
      b_reg    <= facB;
      cnt_reg  <= 2'h1;
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      acc_reg  <= acc_reg + step(a_reg, b_reg[{cnt_reg, 1'b1} -: 2], cnt_reg);
      cnt_reg  <= cnt_reg + 2'h1;
      busy_reg <= !done;
    end
  end

endmodule : emoe_mul8

/* emoe_core.sv */
`timescale 1ns/100ps
// Function
// - indexed external read, one byte, two cycles
// - index register value is low-port address
// - pointer high byte on high port, latch kept
// - unsigned product, low to acc, four cycles
// - product over 255 sets excess flag
// - multiply always clears carry
// - idle only advances program counter
// - byte OR writes destination, flags untouched unless destination is the status word
// - acc OR from register, direct, indirect, immediate
// - OR into port reads output latch, not pins; acc OR from general port reads pins, from high port the latch
// - direct OR sets masked bits anywhere
// - acc OR direct, two bytes, one cycle
// - acc OR immediate, two bytes, one cycle
// - direct OR acc, two bytes, one cycle
// - direct OR immediate, three bytes
module emoe_core
  import emoe_pkg::*;
(
  input  wire logic        sys_clk,     // machine-cycle clock
  input  wire logic        rst_b,       // async reset
  output logic [15:0]      codeAddr,    // program counter
  input  wire emoe_code_s  code,        // bytes at codeAddr
  output emoe_xbus_s       xbus,        // external bus
  input  wire logic [7:0]  lowPortIn,   // low port pins
  input  wire logic [7:0]  gpPortPins,  // general port pins
  output logic [7:0]       gpPortOut,   // general port latch
  output logic [7:0]       accOut,      // accumulator
  output logic [7:0]       auxOut,      // auxiliary factor register
  output logic [7:0]       pswOut,      // status word
  output logic             unsupported  // opcode outside slice
);

  ////////////////////////////////////////////////////////////////////
  // state
  emoe_state_e state_reg;     // sequencer
  logic [15:0] pc_reg;        // program counter
  logic [7:0]  acc_reg;       // accumulator
  logic [7:0]  aux_reg;       // auxiliary factor
  logic [7:0]  psw_reg;       // status word
  logic [7:0]  ptrLo_reg;     // data_pointer_low
  logic [7:0]  ptrHi_reg;     // data_pointer_high
  logic [7:0]  gpLatch_reg;   // general port latch
  logic [7:0]  hiLatch_reg;   // high_address_port latch
  logic [7:0]  ram [0:127];   // internal data ram
  logic        xWrite_reg;    // pending transfer is a write
  logic        xUseDp_reg;    // pending transfer uses pointer
  logic [7:0]  xHigh_reg;     // high address of transfer

  ////////////////////////////////////////////////////////////////////
  // decode
  emoe_cls_e   cls;           // class of current opcode
  logic        exec;          // decode cycle
  logic [1:0]  rs;            // bank select
  logic [7:0]  bankVal;       // bank_work_reg value
  logic [7:0]  idxVal;        // indirect_index_reg value
  logic [7:0]  indVal;        // byte at idxVal
  logic [7:0]  orA;           // OR result into acc
  logic [7:0]  orD;           // OR result into direct
  logic        dirWe;         // direct write this cycle
  logic [7:0]  dirAddr;       // direct write address
  logic        prodStart;     // launch multiply
  logic        prodDone;      // multiply final cycle
  logic [15:0] prodVal;       // product

  assign exec  = (state_reg == ST_EXEC);
  assign cls   = emoe_decode(code.op);
  assign rs    = psw_reg[PSW_RSH:PSW_RSL];
  assign bankVal = ram[{2'b00, rs, code.op[2:0]}];
  assign idxVal  = ram[{2'b00, rs, 2'b00, code.op[0]}];
  // indirect reach is the lower 128 bytes only
  assign indVal = idxVal[7] ? 8'h00 : ram[idxVal[6:0]];

  // direct-space read; latch view for read-modify-write of ports
  function automatic logic [7:0] dirRead(input logic [7:0] a, input logic latchView);
    logic [7:0] v;
    v = 8'h00;
    if (!a[7]) v = ram[a[6:0]];
    else begin
      unique case (a)
        ADDR_ACC:    v = acc_reg;
        ADDR_AUX:    v = aux_reg;
        ADDR_PSW:    v = psw_reg;
        ADDR_PTRLO:  v = ptrLo_reg;
        ADDR_PTRHI:  v = ptrHi_reg;
        ADDR_GPPORT: v = latchView ? gpLatch_reg : gpPortPins;
        ADDR_HIPORT: v = hiLatch_reg;
        default:     v = 8'h00;
      endcase
    end
    return v;
  endfunction : dirRead

  // OR sources and results
  always_comb begin
    unique case (cls)
      CLS_OR_REG: orA = acc_reg | bankVal;
      CLS_OR_IND: orA = acc_reg | indVal;
      CLS_OR_DIR: orA = acc_reg | dirRead(code.arg1, 1'b0);
      CLS_OR_IMM: orA = acc_reg | code.arg1;
      default:    orA = acc_reg;
    endcase
    orD = dirRead(code.arg1, 1'b1) |
          ((cls == CLS_OR_DIRI) ? code.arg2 : acc_reg);
  end

  assign dirWe   = exec && (cls == CLS_OR_DIRA || cls == CLS_OR_DIRI);
  assign dirAddr = code.arg1;
  assign prodStart = exec && (cls == CLS_PROD);
  assign unsupported = exec && (cls == CLS_OTHER);

  emoe_mul8 u_prod (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .start   (prodStart),
    .facA    (acc_reg),
    .facB    (aux_reg),
    .done    (prodDone),
    .product (prodVal)
  );

  ////////////////////////////////////////////////////////////////////
  // sequencer and program counter
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_EXEC;
      pc_reg    <= RST_PC;
    end else begin
      unique case (state_reg)
        ST_EXEC: begin
          if (cls inside {CLS_XRD_IDX, CLS_XRD_DP, CLS_XWR_IDX, CLS_XWR_DP}) begin
            state_reg <= ST_XDATA;
          end else if (cls == CLS_PROD) begin
            state_reg <= ST_PROD;
          end else begin
            pc_reg <= pc_reg + emoe_len(cls);
          end
        end
        ST_XDATA: begin
          state_reg <= ST_EXEC;
          pc_reg    <= pc_reg + 16'h0001;
        end
        ST_PROD: begin
          if (prodDone) begin
            state_reg <= ST_EXEC;
            pc_reg    <= pc_reg + 16'h0001;
          end
        end
      endcase
    end
  end

  // transfer details held for the data cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      xWrite_reg <= 1'b0;
      xUseDp_reg <= 1'b0;
      xHigh_reg  <= RST_BYTE;
    end else if (exec) begin
      xWrite_reg <= (cls == CLS_XWR_IDX || cls == CLS_XWR_DP);
      xUseDp_reg <= (cls == CLS_XRD_DP || cls == CLS_XWR_DP);
      xHigh_reg  <= ptrHi_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // external bus: address cycle, then data cycle
  always_comb begin
    xbus         = '0;
    xbus.rdStb_b = 1'b1;
    xbus.wrStb_b = 1'b1;
    xbus.lowOut  = RST_PORT;
    xbus.highOut = hiLatch_reg;
    if (exec && (cls == CLS_XRD_IDX || cls == CLS_XWR_IDX)) begin
      xbus.ale    = 1'b1;
      xbus.lowOe  = 1'b1;
      xbus.lowOut = idxVal;
    end else if (exec && (cls == CLS_XRD_DP || cls == CLS_XWR_DP)) begin
      xbus.ale     = 1'b1;
      xbus.lowOe   = 1'b1;
      xbus.lowOut  = ptrLo_reg;
      xbus.highOut = ptrHi_reg;
    end else if (state_reg == ST_XDATA) begin
      xbus.rdStb_b = xWrite_reg;
      xbus.wrStb_b = !xWrite_reg;
      xbus.lowOe   = xWrite_reg;
      xbus.lowOut  = xWrite_reg ? acc_reg : RST_PORT;
      xbus.highOut = xUseDp_reg ? xHigh_reg : hiLatch_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // accumulator
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) acc_reg <= RST_BYTE;
    else if (state_reg == ST_XDATA && !xWrite_reg) acc_reg <= lowPortIn;
    else if (state_reg == ST_PROD && prodDone) acc_reg <= prodVal[7:0];
    else if (dirWe && dirAddr == ADDR_ACC) acc_reg <= orD;
    else if (exec) acc_reg <= orA;
  end

  // auxiliary factor register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) aux_reg <= RST_BYTE;
    else if (state_reg == ST_PROD && prodDone) aux_reg <= prodVal[15:8];
    else if (dirWe && dirAddr == ADDR_AUX) aux_reg <= orD;
  end

  // status word; OR leaves flags alone unless it targets the word itself
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) psw_reg <= RST_BYTE;
    else if (state_reg == ST_PROD && prodDone) begin
      psw_reg[PSW_EXCESS] <= (prodVal[15:8] != 8'h00);
      psw_reg[PSW_CY] <= 1'b0;
    end else if (dirWe && dirAddr == ADDR_PSW) psw_reg <= orD;
  end

  // data pointer halves
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptrLo_reg <= RST_BYTE;
      ptrHi_reg <= RST_BYTE;
    end else if (dirWe) begin
      if (dirAddr == ADDR_PTRLO) ptrLo_reg <= orD;
      if (dirAddr == ADDR_PTRHI) ptrHi_reg <= orD;
    end
  end

  // port latches; the transfer never loads the high latch
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gpLatch_reg <= RST_PORT;
      hiLatch_reg <= RST_PORT;
    end else if (dirWe) begin
      if (dirAddr == ADDR_GPPORT) gpLatch_reg <= orD;
      if (dirAddr == ADDR_HIPORT) hiLatch_reg <= orD;
    end
  end

  // internal ram, written only by direct-destination OR
  always_ff @(posedge sys_clk) begin
    if (dirWe && !dirAddr[7]) ram[dirAddr[6:0]] <= orD;
  end

  assign codeAddr  = pc_reg;
  assign gpPortOut = gpLatch_reg;
  assign accOut    = acc_reg;
  assign auxOut    = aux_reg;
  assign pswOut    = psw_reg;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_xfer;
    (state_reg == ST_XDATA) ##1 (state_reg == ST_EXEC);
  endsequence

  sequence s_prodRun;
    (state_reg == ST_PROD && !prodDone) [*2] ##1 (state_reg == ST_PROD && prodDone);
  endsequence

  chk_xrd_two_cycles: assert property (
    exec && cls == CLS_XRD_IDX |=> s_xfer ##0 (pc_reg == $past(pc_reg, 2) + 16'h0001))
    else $error("indexed read not two cycles");

  chk_idx_address: assert property (
    exec && (cls == CLS_XRD_IDX || cls == CLS_XWR_IDX)
    |-> xbus.ale && xbus.lowOe && xbus.lowOut == idxVal) else $error("bad index address");

  chk_dp_high_byte: assert property (
    exec && cls == CLS_XWR_DP |=>
    xbus.highOut == $past(ptrHi_reg) && hiLatch_reg == $past(hiLatch_reg))
    else $error("pointer high byte wrong");

  chk_xwr_data: assert property (
    exec && cls == CLS_XWR_IDX |=> !xbus.wrStb_b && xbus.rdStb_b && xbus.lowOe &&
    xbus.lowOut == acc_reg) else $error("write cycle bad");

  chk_xrd_capture: assert property (
    state_reg == ST_XDATA && !xWrite_reg |=> acc_reg == $past(lowPortIn))
    else $error("read data not loaded");

  chk_prod_result: assert property (
    prodStart |=> s_prodRun ##1
    ({aux_reg, acc_reg} == {8'h00, $past(acc_reg, 4)} * {8'h00, $past(aux_reg, 4)}))
    else $error("product wrong or late");

  chk_prod_flags: assert property (
    state_reg == ST_PROD && prodDone |=>
    psw_reg[PSW_EXCESS] == (aux_reg != 8'h00) && !psw_reg[PSW_CY])
    else $error("multiply flags wrong");

  chk_idle_pc: assert property (
    exec && cls == CLS_IDLE |=> pc_reg == $past(pc_reg) + 16'h0001 &&
    $stable(acc_reg) && $stable(psw_reg) && $stable(aux_reg))
    else $error("idle changed state");

  chk_or_flags: assert property (
    exec && cls inside {CLS_OR_REG, CLS_OR_IND, CLS_OR_DIR, CLS_OR_IMM} |=> $stable(psw_reg))
    else $error("OR touched flags");

  chk_or_register: assert property (
    exec && cls == CLS_OR_REG |=> acc_reg == ($past(acc_reg) | $past(bankVal)))
    else $error("register OR wrong");

  chk_or_latch: assert property (
    exec && cls == CLS_OR_DIRA && code.arg1 == ADDR_GPPORT |=>
    gpLatch_reg == ($past(gpLatch_reg) | $past(acc_reg))) else $error("port OR used pins");

  chk_or_imm_len: assert property (
    exec && (cls == CLS_OR_IMM || cls == CLS_OR_DIR) |=> pc_reg == $past(pc_reg) + 16'h0002)
    else $error("two-byte OR length");

  chk_or_dirimm: assert property (
    exec && cls == CLS_OR_DIRI && code.arg1 == ADDR_AUX |=> pc_reg == $past(pc_reg) + 16'h0003
    && aux_reg == ($past(aux_reg) | $past(code.arg2))) else $error("three-byte OR wrong");

endmodule : emoe_core

/* emoe_xmem.sv */
`timescale 1ns/100ps
module emoe_xmem
  import emoe_pkg::*;
(
  input  wire logic       sys_clk,  // machine-cycle clock
  input  wire emoe_xbus_s xbus,     // device side of the external bus
  output logic [7:0]      lowWire   // resolved low port level
);
  logic [7:0]  mem [0:65535];  // external data bytes
  logic [15:0] addrReg;        // address captured in the address cycle
  logic [7:0]  lastReg = 8'h00;  // last level seen on the low port

  ////////////////////////////////////////////////////////////////////////////////
  // preset contents, a pattern derived from the address
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ 8'hA5;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // wire level: device drive wins, memory drives only while read strobe low
  always_comb begin
    if (xbus.lowOe) begin
      lowWire = xbus.lowOut;  // device drives address or write data
    end else if (!xbus.rdStb_b) begin
      lowWire = mem[addrReg];  // memory answers the read
    end else begin
      lowWire = ~lastReg;  // released bus, never a stale copy
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // address capture on the latch strobe, write at end of strobe cycle
  always @(posedge sys_clk) begin
    if (xbus.ale) begin
      addrReg <= {xbus.highOut, xbus.lowOut};  // high port : low port
    end
    if (!xbus.wrStb_b) begin
      mem[addrReg] <= lowWire;  // byte from the device
    end
    lastReg <= lowWire;  // floating value toggles every cycle
  end

endmodule : emoe_xmem

/* ext_move_multiply_or_exec_bench.sv */
`timescale 1ns/100ps
// one comparison, counted, mismatch printed at once
`define CHECK(nm, exp, got) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("unexpected %s: expected %h, seen %h", nm, exp, got); \
  end \
end

module ext_move_multiply_or_exec_bench
  import emoe_pkg::*;
;
  // one instruction and the state it should leave
  typedef struct packed {
    logic [7:0] op, arg1, arg2, len, cyc, pins, acc, aux, psw, gp;
  } emoe_row_s;

  logic        sys_clk = 1'b0;  // 25 MHz machine clock
  logic        rst_b;           // async reset, low
  logic [15:0] codeAddr;        // program counter seen
  emoe_code_s  codeBytes;       // bytes at the program counter
  emoe_xbus_s  xbus;            // external bus from the device
  logic [7:0]  lowWire;         // resolved low port
  logic [7:0]  gpPins;          // general port pins
  logic [7:0]  gpOut;           // general port latch
  logic [7:0]  acc;             // accumulator
  logic [7:0]  aux;             // auxiliary factor register
  logic [7:0]  psw;             // status word
  logic        unsupportedOp;   // opcode outside slice
  logic [7:0]  rom [0:255];     // program bytes
  int          error_cnt = 0;   // mismatches
  int          tests_run = 0;   // comparisons made

  // op arg1 arg2 len cyc pins | acc aux psw gp
  emoe_row_s rows [29] = '{
    80'h00_00_00_01_01_00_00_00_00_FF,
    80'h44_10_00_02_01_00_10_00_00_FF,
    80'h43_F0_10_03_01_00_10_10_00_FF,
    80'h43_D0_80_03_01_00_10_10_80_FF,
    80'hA4_00_00_01_04_00_00_01_04_FF,
    80'h43_D0_80_03_01_00_00_01_84_FF,
    80'h44_FF_00_02_01_00_FF_01_84_FF,
    80'hA4_00_00_01_04_00_FF_00_00_FF,
    80'hA4_00_00_01_04_00_00_00_00_FF,
    80'h44_50_00_02_01_00_50_00_00_FF,
    80'h43_F0_A0_03_01_00_50_A0_00_FF,
    80'hA4_00_00_01_04_00_00_32_04_FF,
    80'h44_C3_00_02_01_00_C3_32_04_FF,
    80'h43_00_FF_03_01_00_C3_32_04_FF,
    80'h45_90_00_02_01_14_D7_32_04_FF,
    80'h42_90_00_02_01_00_D7_32_04_FF,
    80'h42_82_00_02_01_00_D7_32_04_FF,
    80'h43_83_12_03_01_00_D7_32_04_FF,
    80'h46_00_00_01_01_00_D7_32_04_FF,
    80'hE2_00_00_01_02_00_5A_32_04_FF,
    80'hF0_00_00_01_02_00_5A_32_04_FF,
    80'h44_A5_00_02_01_00_FF_32_04_FF,
    80'hE0_00_00_01_02_00_5A_32_04_FF,
    80'h44_A5_00_02_01_00_FF_32_04_FF,
    80'hF2_00_00_01_02_00_FF_32_04_FF,
    80'hA4_00_00_01_04_00_CE_31_04_FF,
    80'hE2_00_00_01_02_00_FF_31_04_FF,
    80'hA4_00_00_01_04_00_CF_30_04_FF,
    80'h48_00_00_01_01_00_FF_30_04_FF
  };

  ////////////////////////////////////////////////////////////////////////////////
  // clock and program memory
  always #20 sys_clk = ~sys_clk;

  assign codeBytes = {rom[codeAddr[7:0]], rom[codeAddr[7:0] + 8'h01],
                      rom[codeAddr[7:0] + 8'h02]};

  emoe_core dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .codeAddr(codeAddr), .code(codeBytes),
    .xbus(xbus), .lowPortIn(lowWire), .gpPortPins(gpPins), .gpPortOut(gpOut),
    .accOut(acc), .auxOut(aux), .pswOut(psw), .unsupported(unsupportedOp)
  );

  emoe_xmem xm (.sys_clk(sys_clk), .xbus(xbus), .lowWire(lowWire));

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic stop_test();
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  // watchdog, far beyond the roughly sixty cycles needed
  initial begin
    #(40 * 2000);
    error_cnt++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin : main
    logic [7:0] pcExp;  // expected program counter
    rst_b = 1'b0;
    gpPins = 8'h00;
    for (int i = 0; i < 256; i++) rom[i] = 8'h00;
    pcExp = 8'h00;
    foreach (rows[i]) begin  // lay the rows out as one program
      rom[pcExp] = rows[i].op;
      rom[pcExp + 8'h01] = rows[i].arg1;
      rom[pcExp + 8'h02] = rows[i].arg2;
      pcExp = pcExp + rows[i].len;
    end
    rom[pcExp] = 8'hF0;  // trailing pointer write, watched on the bus
    repeat (2) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    pcExp = 8'h00;
    foreach (rows[i]) begin  // ordinary cases
      gpPins = rows[i].pins;
      repeat (rows[i].cyc) @(posedge sys_clk);
      #1;
      pcExp = pcExp + rows[i].len;
      `CHECK("codeAddr", {8'h00, pcExp}, codeAddr)
      `CHECK("acc", rows[i].acc, acc)
      `CHECK("aux", rows[i].aux, aux)
      `CHECK("psw", rows[i].psw, psw & 8'hFE)
      `CHECK("gpPortOut", rows[i].gp, gpOut)
      `CHECK("unsupported", 1'b0, unsupportedOp)
    end
    // pointer write: address cycle, data cycle, latch back on high port
    `CHECK("addrStrobe", 2'h3, {xbus.ale, xbus.lowOe})
    `CHECK("addrBytes", 16'h12D7, {xbus.highOut, xbus.lowOut})
    @(posedge sys_clk);
    #1;
    `CHECK("wrStb_b", 1'b0, xbus.wrStb_b)
    `CHECK("wrData", 8'hFF, xbus.lowOut)
    `CHECK("dataHigh", 8'h12, xbus.highOut)
    @(posedge sys_clk);
    #1;
    `CHECK("latchHigh", 8'hFF, xbus.highOut)
    `CHECK("xmemByte", 8'hFF, xm.mem[16'h12D7])
    // reset in mid-run, then the program starts over
    rom[1] = 8'hA5;  // opcode outside the slice, runs as a one-byte idle
    rst_b = 1'b0;
    #5;
    `CHECK("rstPc", 16'h0000, codeAddr)
    `CHECK("rstRegs", {8'h00, 8'h00, 8'h00, 8'hFF}, {acc, aux, psw, gpOut})
    `CHECK("rstStrobes", 4'h6, {xbus.ale, xbus.rdStb_b, xbus.wrStb_b, xbus.lowOe})
    `CHECK("rstHigh", 8'hFF, xbus.highOut)
    repeat (2) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    @(posedge sys_clk);
    #1;
    `CHECK("idlePc", 16'h0001, codeAddr)
    `CHECK("unsupported", 1'b1, unsupportedOp)
    @(posedge sys_clk);
    #1;
    `CHECK("otherPc", 16'h0002, codeAddr)
    `CHECK("otherAcc", 8'h00, acc)
    stop_test();
  end

endmodule : ext_move_multiply_or_exec_bench
